//--- verilog/fpic_pkg.sv
/*
 Shared constants and types of the flash protection, timing and interrupt controller.
 Assumes a 256-KB flash array of 32-bit words reached through a simple one-cycle read port.
*/
`default_nettype none
package fpic_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int FLASH_AW = 18;
	localparam int WORD_AW = 16;
	localparam int PAGE_LSB = 10;
	localparam int UNIT_LSB = 11;
	localparam int UNIT_W = 7;
	localparam int PROT_REGS = 4;
	localparam int PROT_BITS = 128;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam logic [11:0] OFF_TARGET_ADDR = 12'h000;
	localparam logic [11:0] OFF_WRITE_DATA = 12'h004;
	localparam logic [11:0] OFF_CONTROL = 12'h008;
	localparam logic [11:0] OFF_RAW_STATUS = 12'h00c;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h014;
	localparam logic [11:0] OFF_USEC_RELOAD = 12'h140;
	localparam logic [11:0] OFF_READ_EN0 = 12'h200;
	localparam logic [11:0] OFF_PROG_EN0 = 12'h400;
	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CMD_KEY_LSB = 16;
	localparam logic [15:0] CMD_KEY = 16'ha442;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_ERASE_BIT = 1;
	localparam int CMD_COMMIT_BIT = 3;
	localparam int STAT_ACCESS_BIT = 0;
	localparam int STAT_PROG_BIT = 1;
	localparam logic [7:0] USEC_RELOAD_RESET = 8'h31;
	localparam logic [31:0] PROT_FACTORY = 32'hffffffff;
	localparam int COMMIT_SEL_W = 3;
	// ----------------------------------------------------------------
	// Timing, in microseconds
	// ----------------------------------------------------------------
	localparam int PROG_TIME_US = 20;
	localparam int ERASE_TIME_US = 20000;
	localparam int US_CNT_W = 20;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_FETCH = 2'h0,
		KIND_DATA = 2'h1,
		KIND_DEBUG = 2'h2
	} fpic_kind_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_READ_CUR = 3'h1,
		ST_PROGRAM = 3'h3,
		ST_DONE = 3'h2,
		ST_ERASE = 3'h6
	} fpic_state_type;
	// Protection unit index of a byte address.
	function automatic logic [UNIT_W-1:0] fpic_unit(input logic [FLASH_AW-1:0] addr);
		fpic_unit = addr[UNIT_LSB +: UNIT_W];
	endfunction
	// Bit of a 128-bit policy vector made of four 32-bit registers.
	function automatic logic fpic_bit(input logic [PROT_BITS-1:0] v, input logic [UNIT_W-1:0] u);
		fpic_bit = v[u];
	endfunction
endpackage
`default_nettype wire

//--- verilog/fpic_top.sv
/*
 Flash controller: protection policy, program and erase sequencing, timing and status.
 Assumes an APB master for registers, a system bus read port held until ready, a flash
 array with a one-cycle synchronous read and level program and erase strobes, and a
 nonvolatile store that holds committed protection words.
*/
`timescale 1ns/10ps
`default_nettype none
module fpic_top #(
	parameter int PROG_US = fpic_pkg::PROG_TIME_US,
	parameter int ERASE_US = fpic_pkg::ERASE_TIME_US
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic porn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fpic_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sb_valid,
	input wire logic [1:0] sb_kind,
	input wire logic [fpic_pkg::FLASH_AW-1:0] sb_addr,
	output logic sb_ready,
	output logic [31:0] sb_rdata,
	output logic sb_fault,
	output logic [fpic_pkg::WORD_AW-1:0] arr_addr,
	output logic arr_read,
	input wire logic [31:0] arr_rdata,
	output logic [31:0] arr_wdata,
	output logic arr_prog,
	output logic arr_erase,
	input wire logic [fpic_pkg::PROT_BITS-1:0] nv_read_enable_bits,
	input wire logic [fpic_pkg::PROT_BITS-1:0] nv_program_enable_bits,
	output logic nv_commit,
	output logic [fpic_pkg::COMMIT_SEL_W-1:0] nv_commit_sel,
	output logic [31:0] nv_commit_data,
	output logic flash_irq
);
	import fpic_pkg::*;

	initial begin
		if (PROG_US < 1 || PROG_US >= (1 << US_CNT_W)) begin
			$error("PROG_US out of range");
		end
		if (ERASE_US < 1 || ERASE_US >= (1 << US_CNT_W)) begin
			$error("ERASE_US out of range");
		end
	end

	localparam logic [US_CNT_W-1:0] PROG_LOAD = US_CNT_W'(PROG_US - 1);
	localparam logic [US_CNT_W-1:0] ERASE_LOAD = US_CNT_W'(ERASE_US - 1);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0] flash_target_address_reg;
	logic [31:0] flash_write_data_reg;
	logic [7:0] microsecond_reload_count_reg;
	logic [1:0] flash_irq_mask_reg;
	logic [1:0] flash_raw_irq_status_reg;
	logic [31:0] block_read_enable_bits_reg [PROT_REGS];
	logic [31:0] block_program_enable_bits_reg [PROT_REGS];
	logic nv_load_pending_reg;
	logic cmd_write_reg;
	logic cmd_erase_reg;
	fpic_state_type state_reg;
	logic [FLASH_AW-1:0] op_addr_reg;
	logic [31:0] op_data_reg;
	logic [US_CNT_W-1:0] us_left_reg;
	logic [7:0] usec_div_reg;
	logic sb_pending_reg;
	logic sb_done_reg;
	logic [31:0] sb_rdata_reg;
	logic sb_fault_reg;
	logic [31:0] arr_wdata_reg;
	logic cur_wait_reg;
	logic nv_commit_reg;
	logic [COMMIT_SEL_W-1:0] nv_commit_sel_reg;
	logic [31:0] nv_commit_data_reg;

	logic apb_wr;
	logic apb_rd;
	logic [PROT_BITS-1:0] read_en_vec;
	logic [PROT_BITS-1:0] prog_en_vec;
	logic key_ok;
	logic cmd_wr;
	logic req_write;
	logic req_erase;
	logic req_commit;
	logic target_open;
	logic start_op;
	logic refuse_op;
	logic us_tick;
	logic op_done;
	logic [1:0] status_set;
	logic [1:0] status_clr;
	logic [1:0] flash_masked_irq_status;
	logic sb_take;
	logic sb_denied;

	always_comb begin
		for (int i = 0; i < PROT_REGS; i++) begin
			read_en_vec[i*32 +: 32] = block_read_enable_bits_reg[i];
			prog_en_vec[i*32 +: 32] = block_program_enable_bits_reg[i];
		end
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign cmd_wr = apb_wr && (paddr == OFF_CONTROL);
	assign key_ok = pwdata[CMD_KEY_LSB +: 16] == CMD_KEY;
	assign req_write = cmd_wr && key_ok && pwdata[CMD_WRITE_BIT] && state_reg == ST_IDLE;
	assign req_erase = cmd_wr && key_ok && !pwdata[CMD_WRITE_BIT] && pwdata[CMD_ERASE_BIT]
		&& state_reg == ST_IDLE;
	assign req_commit = cmd_wr && key_ok && pwdata[CMD_COMMIT_BIT] && state_reg == ST_IDLE
		&& !pwdata[CMD_WRITE_BIT] && !pwdata[CMD_ERASE_BIT]
		&& flash_target_address_reg[31:COMMIT_SEL_W] == '0;
	assign target_open = fpic_bit(prog_en_vec,
		fpic_unit(flash_target_address_reg[FLASH_AW-1:0]));
	assign start_op = (req_write || req_erase) && target_open;
	assign refuse_op = (req_write || req_erase) && !target_open;

	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		unique case (paddr)
			OFF_TARGET_ADDR: prdata = flash_target_address_reg;
			OFF_WRITE_DATA: prdata = flash_write_data_reg;
			OFF_CONTROL: prdata = {30'h0, cmd_erase_reg, cmd_write_reg};
			OFF_RAW_STATUS: prdata = {30'h0, flash_raw_irq_status_reg};
			OFF_IRQ_MASK: prdata = {30'h0, flash_irq_mask_reg};
			OFF_IRQ_CLEAR: prdata = {30'h0, flash_masked_irq_status};
			OFF_USEC_RELOAD: prdata = {24'h0, microsecond_reload_count_reg};
			OFF_READ_EN0, OFF_READ_EN0 + 12'h004, OFF_READ_EN0 + 12'h008,
			OFF_READ_EN0 + 12'h00c: prdata = block_read_enable_bits_reg[paddr[3:2]];
			OFF_PROG_EN0, OFF_PROG_EN0 + 12'h004, OFF_PROG_EN0 + 12'h008,
			OFF_PROG_EN0 + 12'h00c: prdata = block_program_enable_bits_reg[paddr[3:2]];
			default: pslverr = apb_wr || apb_rd;
		endcase
	end

	// ----------------------------------------------------------------
	// Software registers on the normal reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flash_target_address_reg <= 32'h0;
			flash_write_data_reg <= 32'h0;
			flash_irq_mask_reg <= 2'h0;
			microsecond_reload_count_reg <= USEC_RELOAD_RESET;
		end else if (apb_wr) begin
			if (paddr == OFF_TARGET_ADDR) begin
				flash_target_address_reg <= pwdata;
			end
			if (paddr == OFF_WRITE_DATA) begin
				flash_write_data_reg <= pwdata;
			end
			if (paddr == OFF_IRQ_MASK) begin
				flash_irq_mask_reg <= pwdata[1:0];
			end
			if (paddr == OFF_USEC_RELOAD) begin
				microsecond_reload_count_reg <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Protection registers
	// ----------------------------------------------------------------
	// Only power-on reset touches these, so an uncommitted clear survives a normal reset.
	// Committed words are reloaded from the nonvolatile store one edge after release.
	always_ff @(posedge clk or negedge porn) begin
		if (!porn) begin
			nv_load_pending_reg <= 1'b1;
			for (int i = 0; i < PROT_REGS; i++) begin
				block_read_enable_bits_reg[i] <= PROT_FACTORY;
				block_program_enable_bits_reg[i] <= PROT_FACTORY;
			end
		end else if (nv_load_pending_reg) begin
			nv_load_pending_reg <= 1'b0;
			for (int i = 0; i < PROT_REGS; i++) begin
				block_read_enable_bits_reg[i] <= nv_read_enable_bits[i*32 +: 32];
				block_program_enable_bits_reg[i] <= nv_program_enable_bits[i*32 +: 32];
			end
		end else if (apb_wr) begin
			for (int i = 0; i < PROT_REGS; i++) begin
				if (paddr == OFF_READ_EN0 + 12'(4 * i)) begin
					block_read_enable_bits_reg[i] <= block_read_enable_bits_reg[i] & pwdata;
				end
				if (paddr == OFF_PROG_EN0 + 12'(4 * i)) begin
					block_program_enable_bits_reg[i] <= block_program_enable_bits_reg[i] & pwdata;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Commit to the nonvolatile store
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nv_commit_reg <= 1'b0;
			nv_commit_sel_reg <= '0;
			nv_commit_data_reg <= 32'h0;
		end else begin
			nv_commit_reg <= req_commit;
			if (req_commit) begin
				nv_commit_sel_reg <= flash_target_address_reg[COMMIT_SEL_W-1:0];
				nv_commit_data_reg <= flash_target_address_reg[0]
					? block_program_enable_bits_reg[flash_target_address_reg[2:1]]
					: block_read_enable_bits_reg[flash_target_address_reg[2:1]];
			end
		end
	end

	// ----------------------------------------------------------------
	// Microsecond divider
	// ----------------------------------------------------------------
	// Restarted with each operation so that the first microsecond is a whole one.
	assign us_tick = usec_div_reg == 8'h0;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			usec_div_reg <= USEC_RELOAD_RESET;
		end else if (start_op || us_tick || state_reg == ST_READ_CUR) begin
			usec_div_reg <= microsecond_reload_count_reg;
		end else begin
			usec_div_reg <= usec_div_reg - 8'h1;
		end
	end

	// ----------------------------------------------------------------
	// Program and erase sequencer
	// ----------------------------------------------------------------
	assign op_done = state_reg == ST_DONE;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			op_addr_reg <= '0;
			op_data_reg <= 32'h0;
			us_left_reg <= '0;
			arr_wdata_reg <= 32'h0;
			cur_wait_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_op) begin
						op_addr_reg <= flash_target_address_reg[FLASH_AW-1:0];
						op_data_reg <= flash_write_data_reg;
						us_left_reg <= req_write ? PROG_LOAD : ERASE_LOAD;
						state_reg <= req_write ? ST_READ_CUR : ST_ERASE;
					end
				end
				// The array answers one cycle after the read strobe, so the word is taken later.
				ST_READ_CUR: begin
					cur_wait_reg <= !cur_wait_reg;
					if (cur_wait_reg) begin
						state_reg <= ST_PROGRAM;
					end
				end
				ST_PROGRAM, ST_ERASE: begin
					if (us_tick) begin
						us_left_reg <= us_left_reg - US_CNT_W'(1);
						if (us_left_reg == '0) begin
							state_reg <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
			if (state_reg == ST_READ_CUR && cur_wait_reg) begin
				arr_wdata_reg <= arr_rdata & op_data_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_write_reg <= 1'b0;
			cmd_erase_reg <= 1'b0;
		end else if (start_op) begin
			cmd_write_reg <= req_write;
			cmd_erase_reg <= req_erase;
		end else if (op_done) begin
			cmd_write_reg <= 1'b0;
			cmd_erase_reg <= 1'b0;
		end
	end

	assign arr_prog = state_reg == ST_PROGRAM;
	assign arr_erase = state_reg == ST_ERASE;
	assign arr_wdata = arr_wdata_reg;
	assign arr_read = sb_take && !sb_denied || (state_reg == ST_READ_CUR && !cur_wait_reg);
	// The erase address names the 1-KB page; the array clears the whole page.
	always_comb begin
		if (state_reg == ST_IDLE) begin
			arr_addr = sb_addr[FLASH_AW-1:2];
		end else if (state_reg == ST_ERASE) begin
			arr_addr = {op_addr_reg[FLASH_AW-1:PAGE_LSB], 8'h0};
		end else begin
			arr_addr = op_addr_reg[FLASH_AW-1:2];
		end
	end

	// ----------------------------------------------------------------
	// Status and interrupt
	// ----------------------------------------------------------------
	assign status_set[STAT_ACCESS_BIT] = refuse_op;
	assign status_set[STAT_PROG_BIT] = op_done;
	assign status_clr = (apb_wr && paddr == OFF_IRQ_CLEAR) ? pwdata[1:0] : 2'h0;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flash_raw_irq_status_reg <= 2'h0;
		end else begin
			// A new event in the clearing cycle is kept.
			flash_raw_irq_status_reg <= (flash_raw_irq_status_reg & ~status_clr) | status_set;
		end
	end
	assign flash_masked_irq_status = flash_raw_irq_status_reg & flash_irq_mask_reg;
	assign flash_irq = |flash_masked_irq_status;

	// ----------------------------------------------------------------
	// System bus reads
	// ----------------------------------------------------------------
	// Reads wait while the array is busy programming or erasing.
	assign sb_take = sb_valid && state_reg == ST_IDLE && !sb_pending_reg && !sb_done_reg;
	assign sb_denied = sb_kind != KIND_FETCH
		&& !fpic_bit(read_en_vec, fpic_unit(sb_addr));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sb_pending_reg <= 1'b0;
			sb_done_reg <= 1'b0;
			sb_rdata_reg <= 32'h0;
			sb_fault_reg <= 1'b0;
		end else begin
			sb_pending_reg <= sb_take && !sb_denied;
			sb_done_reg <= sb_pending_reg || (sb_take && sb_denied);
			if (sb_take && sb_denied) begin
				sb_rdata_reg <= 32'h0;
				sb_fault_reg <= 1'b1;
			end else if (sb_pending_reg) begin
				sb_rdata_reg <= arr_rdata;
				sb_fault_reg <= 1'b0;
			end
		end
	end
	assign sb_ready = sb_done_reg;
	assign sb_rdata = sb_rdata_reg;
	assign sb_fault = sb_fault_reg && sb_done_reg;

	assign nv_commit = nv_commit_reg;
	assign nv_commit_sel = nv_commit_sel_reg;
	assign nv_commit_data = nv_commit_data_reg;
endmodule
`default_nettype wire

//--- tb/fpic_chk.sv
/*
 Port checker for the flash controller top.
 Assumes it is bound into fpic_top and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module fpic_chk
	import fpic_pkg::*;
#(
	parameter int PROG_US = 2,
	parameter int ERASE_US = 3
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fpic_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [1:0] sb_kind,
	input wire logic sb_ready,
	input wire logic [31:0] sb_rdata,
	input wire logic sb_fault,
	input wire logic arr_read,
	input wire logic [31:0] arr_rdata,
	input wire logic [31:0] arr_wdata,
	input wire logic arr_prog,
	input wire logic arr_erase,
	input wire logic nv_commit,
	input wire logic flash_irq
);
	// ----------
	// Shadow state
	// ----------
	logic [31:0] wdata_reg;
	logic [1:0] mask_reg;
	logic pend_reg;
	logic [31:0] cur_reg;
	logic wr_hit;
	assign wr_hit = psel && penable && pwrite;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdata_reg <= 32'h0;
			mask_reg <= 2'h0;
		end else begin
			if (wr_hit && paddr == OFF_WRITE_DATA)
				wdata_reg <= pwdata;
			if (wr_hit && paddr == OFF_IRQ_MASK)
				mask_reg <= pwdata[1:0];
		end
	end
	// The last word read back is the one a program cycle may only clear bits of.
	always_ff @(posedge clk) begin
		pend_reg <= arr_read;
		if (pend_reg)
			cur_reg <= arr_rdata;
	end
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_fault_ready: assert property (sb_fault |-> sb_ready)
		else $error("fault without ready");
	chk_fault_zero: assert property (sb_fault |-> sb_rdata == 32'h0)
		else $error("faulted read returned data");
	chk_fetch_served: assert property (sb_ready && sb_kind == KIND_FETCH |-> !sb_fault)
		else $error("fetch refused");
	chk_prog_and: assert property (arr_prog && $past(arr_prog) |-> arr_wdata == (wdata_reg & cur_reg))
		else $error("program data sets bits");
	chk_prog_end: assert property ($rose(arr_prog) |-> ##[1:300] !arr_prog)
		else $error("program never ends");
	chk_erase_end: assert property ($rose(arr_erase) |-> ##[1:1000] !arr_erase)
		else $error("erase never ends");
	chk_mask_off: assert property (wr_hit && paddr == OFF_IRQ_MASK && pwdata[1:0] == 2'h0 |=> !flash_irq)
		else $error("irq with mask clear");
	chk_clear_all: assert property (wr_hit && paddr == OFF_IRQ_CLEAR && pwdata[1:0] == 2'h3
		&& !$past(arr_prog) && !$past(arr_erase) |=> !flash_irq)
		else $error("irq survives clear");
	chk_done_irq: assert property ($fell(arr_prog) && mask_reg[1] |-> ##1 flash_irq)
		else $error("no irq after program");
	chk_commit_pulse: assert property (nv_commit |=> !nv_commit)
		else $error("commit longer than one cycle");
endmodule
bind fpic_top fpic_chk #(.PROG_US(PROG_US), .ERASE_US(ERASE_US)) i_chk (.clk, .rstn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .sb_kind, .sb_ready, .sb_rdata, .sb_fault, .arr_read,
	.arr_rdata, .arr_wdata, .arr_prog, .arr_erase, .nv_commit, .flash_irq);
`default_nettype wire

//--- tb/fpic_flash_model.sv
/*
 Behavioural flash array facing the controller.
 Assumes word addresses, a one-cycle read answer and level program and erase strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module fpic_flash_model (
	input wire logic clk,
	input wire logic [fpic_pkg::WORD_AW-1:0] arr_addr,
	input wire logic arr_read,
	output logic [31:0] arr_rdata,
	input wire logic [31:0] arr_wdata,
	input wire logic arr_prog,
	input wire logic arr_erase
);
	import fpic_pkg::*;
	// ----------
	// Contents; an absent word reads as erased
	// ----------
	logic [31:0] mem [logic [WORD_AW-1:0]];
	logic [WORD_AW-1:0] op_addr;
	logic [31:0] op_data;
	logic prog_q = 1'b0;
	logic erase_q = 1'b0;
	function automatic logic [31:0] word(input logic [WORD_AW-1:0] a);
		word = mem.exists(a) ? mem[a] : 32'hffffffff;
	endfunction
	// Data lines toggle outside the answer cycle so a stale word never passes for a read.
	always @(posedge clk) begin
		prog_q <= arr_prog;
		erase_q <= arr_erase;
		arr_rdata <= arr_read ? word(arr_addr) : ~arr_rdata;
		if (arr_prog) begin
			op_addr <= arr_addr;
			op_data <= arr_wdata;
		end
		if (prog_q && !arr_prog)
			mem[op_addr] = word(op_addr) & op_data;
		if (arr_erase && !erase_q)
			for (int i = 0; i < 256; i++)
				mem.delete({arr_addr[WORD_AW-1:8], i[7:0]});
	end
endmodule
`default_nettype wire

//--- tb/fpic_top_tb.sv
/*
 Self-checking bench for the flash controller with a behavioural array.
 Assumes a 20 MHz clock and shortened program and erase times.
*/
`timescale 1ns/10ps
`default_nettype none
module fpic_top_tb;
	import fpic_pkg::*;
	// ----------
	// Signals
	// ----------
	localparam int PU = 2;
	localparam logic [31:0] ONES = 32'hffffffff;
	logic clk = 1'b0;
	logic rstn, porn, psel, penable, pwrite, pready, pslverr, slv;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, sb_rdata, arr_rdata, arr_wdata, nv_data;
	logic sb_valid, sb_ready, sb_fault, arr_read, arr_prog, arr_erase, nv_commit, flash_irq;
	logic [1:0] sb_kind;
	logic [FLASH_AW-1:0] sb_addr;
	logic [WORD_AW-1:0] arr_addr;
	logic [COMMIT_SEL_W-1:0] nv_sel;
	logic [PROT_BITS-1:0] nv_re = {4{ONES}};
	logic [PROT_BITS-1:0] nv_pe = {4{ONES}};
	int err_total = 0;
	int tests_run = 0;
	int prog_cnt = 0;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (arr_prog)
			prog_cnt <= prog_cnt + 1;
		if (nv_commit && nv_sel[0])
			nv_pe[nv_sel[2:1] * 32 +: 32] <= nv_data;
		else if (nv_commit)
			nv_re[nv_sel[2:1] * 32 +: 32] <= nv_data;
	end
	fpic_top #(.PROG_US(PU), .ERASE_US(3)) i_dut (.clk, .rstn, .porn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sb_valid, .sb_kind, .sb_addr, .sb_ready,
		.sb_rdata, .sb_fault, .arr_addr, .arr_read, .arr_rdata, .arr_wdata, .arr_prog, .arr_erase,
		.nv_read_enable_bits(nv_re), .nv_program_enable_bits(nv_pe), .nv_commit,
		.nv_commit_sel(nv_sel), .nv_commit_data(nv_data), .flash_irq);
	fpic_flash_model i_arr (.clk, .arr_addr, .arr_read, .arr_rdata, .arr_wdata, .arr_prog,
		.arr_erase);
	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("Counts: %0d compares, %0d errors", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic timeout(input string what);
		err_total++;
		$display("ERROR %0t: no answer on %s", $time, what);
		print_verdict;
	endtask
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			timeout("apb");
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rdchk(input logic [APB_AW-1:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r & m, e, $sformatf("reg %h", a));
	endtask
	task automatic irqchk(input logic e);
		chk({31'h0, flash_irq}, {31'h0, e}, "irq");
	endtask
	task automatic wait_idle;
		logic [31:0] r;
		for (int n = 0; n < 60; n++) begin
			apb(1'b0, OFF_CONTROL, 32'h0, r);
			if (r[1:0] === 2'h0)
				return;
		end
		timeout("busy");
	endtask
	task automatic op(input logic [17:0] a, input logic [31:0] d, input logic [15:0] cmd);
		wr(OFF_WRITE_DATA, d);
		wr(OFF_TARGET_ADDR, {14'h0, a});
		wr(OFF_CONTROL, {CMD_KEY, cmd});
	endtask
	task automatic sbchk(input logic [1:0] k, input logic [17:0] a, input logic [31:0] d,
		input logic f);
		int n = 0;
		sb_valid <= 1'b1;
		sb_kind <= k;
		sb_addr <= a;
		do begin
			@(posedge clk);
			n++;
		end while (sb_ready !== 1'b1 && n < 20);
		if (n >= 20)
			timeout("bus");
		chk(sb_rdata, d, "bus data");
		chk({31'h0, sb_fault}, {31'h0, f}, "bus fault");
		sb_valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rst_pulse(input logic por);
		rstn <= 1'b0;
		porn <= !por;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		porn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_reset_values;
		logic [31:0] r;
		rdchk(OFF_USEC_RELOAD, 32'hff, 32'h31);
		for (int i = 0; i < 4; i++) begin
			rdchk(OFF_READ_EN0 + 12'(4 * i), ONES, ONES);
			rdchk(OFF_PROG_EN0 + 12'(4 * i), ONES, ONES);
		end
		apb(1'b0, 12'hffc, 32'h0, r);
		chk({31'h0, slv}, 32'h1, "unmapped");
		$display("reset values done");
	endtask
	task automatic t_program;
		logic [31:0] r;
		int base;
		wr(OFF_USEC_RELOAD, 32'h3);
		op(18'h100, 32'h0f0f00ff, 16'h1);
		base = prog_cnt;
		rdchk(OFF_CONTROL, 32'h3, 32'h1);
		wait_idle;
		r = prog_cnt - base;
		chk({31'h0, r >= 4 * PU - 1 && r <= 4 * PU + 1}, 32'h1, "program time");
		sbchk(KIND_DATA, 18'h100, 32'h0f0f00ff, 1'b0);
		wr(OFF_USEC_RELOAD, 32'h0);
		op(18'h100, 32'hff00ffff, 16'h1);
		wait_idle;
		sbchk(KIND_DATA, 18'h100, 32'h0f0000ff, 1'b0);
		rdchk(OFF_RAW_STATUS, ONES, 32'h2);
		irqchk(1'b0);
		wr(OFF_IRQ_MASK, 32'h2);
		irqchk(1'b1);
		wr(OFF_IRQ_CLEAR, 32'h0);
		rdchk(OFF_IRQ_CLEAR, ONES, 32'h2);
		wr(OFF_IRQ_CLEAR, 32'h2);
		rdchk(OFF_RAW_STATUS, ONES, 32'h0);
		irqchk(1'b0);
		$display("program done");
	endtask
	task automatic t_erase;
		op(18'h400, 32'h0, 16'h1);
		wait_idle;
		op(18'h100, 32'h0, 16'h2);
		wait_idle;
		sbchk(KIND_DATA, 18'h100, ONES, 1'b0);
		sbchk(KIND_DATA, 18'h400, 32'h0, 1'b0);
		irqchk(1'b1);
		$display("erase done");
	endtask
	task automatic t_protect;
		wr(OFF_PROG_EN0, 32'hfffffffd);
		wr(OFF_PROG_EN0, ONES);
		rdchk(OFF_PROG_EN0, ONES, 32'hfffffffd);
		wr(OFF_IRQ_CLEAR, 32'h3);
		wr(OFF_IRQ_MASK, 32'h1);
		op(18'h800, 32'h0, 16'h1);
		rdchk(OFF_CONTROL, 32'h3, 32'h0);
		rdchk(OFF_RAW_STATUS, ONES, 32'h1);
		irqchk(1'b1);
		wr(OFF_IRQ_CLEAR, 32'h1);
		op(18'hc00, 32'h0, 16'h2);
		rdchk(OFF_RAW_STATUS, ONES, 32'h1);
		sbchk(KIND_DATA, 18'h800, ONES, 1'b0);
		wr(OFF_IRQ_MASK, 32'h0);
		wr(OFF_READ_EN0, 32'hfffffffb);
		op(18'h1000, 32'h12345678, 16'h1);
		wait_idle;
		sbchk(KIND_DATA, 18'h1000, 32'h0, 1'b1);
		sbchk(KIND_DEBUG, 18'h1000, 32'h0, 1'b1);
		sbchk(KIND_FETCH, 18'h1000, 32'h12345678, 1'b0);
		sbchk(KIND_DATA, 18'h17fc, 32'h0, 1'b1);
		sbchk(KIND_DATA, 18'h1800, ONES, 1'b0);
		$display("protection done");
	endtask
	task automatic t_resets;
		rst_pulse(1'b0);
		rdchk(OFF_PROG_EN0, ONES, 32'hfffffffd);
		rdchk(OFF_USEC_RELOAD, 32'hff, 32'h31);
		wr(OFF_TARGET_ADDR, 32'h1);
		wr(OFF_CONTROL, {CMD_KEY, 16'h8});
		repeat (2) @(posedge clk);
		chk(nv_pe[31:0], 32'hfffffffd, "commit");
		rst_pulse(1'b1);
		rdchk(OFF_PROG_EN0, ONES, 32'hfffffffd);
		rdchk(OFF_READ_EN0, ONES, ONES);
		$display("resets done");
	endtask
	initial begin
		rstn = 1'b0;
		porn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		sb_valid = 1'b0;
		sb_kind = 2'h0;
		sb_addr = 18'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		porn <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset_values;
		t_program;
		t_erase;
		t_protect;
		t_resets;
		print_verdict;
	end
endmodule
`default_nettype wire
